// >>> rtl/mbz_params.svh
// Purpose: Register map, field positions, reset values and timing of the sound generator
// Assumes: Registers sit on a plain strobe port, one word per index, byte address = 4*index
// Notes: Definitions only
`ifndef MBZ_PARAMS_SVH
`define MBZ_PARAMS_SVH

`define MBZ_ADDR_W 4
`define MBZ_OFS_CLK 4'h0
`define MBZ_OFS_SEL 4'h1
`define MBZ_OFS_CTL 4'h2
`define MBZ_OFS_DAT 4'h3
`define MBZ_OFS_INTF 4'h4
`define MBZ_OFS_INTE 4'h5

`define MBZ_CLK_DEBUG_RUN 8
`define MBZ_CLK_DIV_LSB 4
`define MBZ_CLK_SRC_LSB 0
`define MBZ_SEL_TEMPO_LSB 8
`define MBZ_SEL_DRIVE 2
`define MBZ_SEL_MODE_LSB 0
`define MBZ_CTL_STOP 8
`define MBZ_CTL_EN 0
`define MBZ_DAT_TIE 15
`define MBZ_DAT_REST 14
`define MBZ_DAT_LEN_LSB 8
`define MBZ_INTF_BUSY 8
`define MBZ_INTF_EMPTY 1
`define MBZ_INTF_DONE 0
`define MBZ_INTE_EMPTY 1
`define MBZ_INTE_DONE 0

`define MBZ_DAT_RESET 16'h00FF
`define MBZ_DIV_UNDIV 3'h7
`define MBZ_DIV_MAX 3'h5

// Tempo unit: one sixty-fourth of a quarter note at code 0 is 48 ticks of the generator clock
`define MBZ_TEMPO_BASE 12'h0C0
`define MBZ_SHOT_BASE 12'h0C0
`define MBZ_SHOT_STEP 12'h200

`endif

// >>> rtl/mbz_pkg.sv
// Purpose: Types of the sound generator
// Assumes: Nothing
// Notes: Constants live in the params header
package mbz_pkg;
    typedef enum logic [1:0] {
        MBZ_MODE_NORMAL = 2'b00,
        MBZ_MODE_ONESHOT = 2'b01,
        MBZ_MODE_MELODY = 2'b10,
        MBZ_MODE_RSVD = 2'b11
    } mbz_mode_t;
    typedef enum logic [1:0] {
        MBZ_SRC_INTOSC = 2'b00,
        MBZ_SRC_LOWXTAL = 2'b01,
        MBZ_SRC_HIGHOSC = 2'b10,
        MBZ_SRC_EXTIN = 2'b11
    } mbz_src_t;
    typedef enum logic [1:0] {
        MBZ_ST_IDLE = 2'b00,
        MBZ_ST_PLAY = 2'b01,
        MBZ_ST_STOP = 2'b10
    } mbz_state_t;
endpackage

// >>> rtl/mbz_clkgen.sv
// Purpose: Generator tick from the selected source, divided by the selected ratio
// Assumes: Source ticks are one-cycle enables synchronous to mclk_i
// Notes: Reserved divider codes give no tick
`include "mbz_params.svh"
`timescale 1ns/1ps
`default_nettype none
module mbz_clkgen (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic run_i,
    input wire logic [1:0] src_i,
    input wire logic [2:0] div_i,
    input wire logic [3:0] src_tick_i,
    output logic tick_o
);
    logic [6:0] cnt_reg;
    logic src_tick;
    logic undiv_src;
    logic div_ok;
    logic [7:0] ratio;
    logic wrap;

    assign src_tick = src_tick_i[src_i];
    assign undiv_src = (src_i == mbz_pkg::MBZ_SRC_LOWXTAL) || (src_i == mbz_pkg::MBZ_SRC_EXTIN);
    // Crystal and external input only undivided, oscillators only divided
    assign div_ok = undiv_src ? (div_i == `MBZ_DIV_UNDIV) : (div_i <= `MBZ_DIV_MAX);
    assign ratio = 8'h04 << div_i;
    assign wrap = ({1'b0, cnt_reg} == ratio - 8'h01);
    assign tick_o = run_i && div_ok && src_tick && (undiv_src || wrap);

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_reg <= 7'h00;
        end else if (!run_i || undiv_src) begin
            cnt_reg <= 7'h00;
        end else if (src_tick) begin
            cnt_reg <= wrap ? 7'h00 : cnt_reg + 7'h01;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/mbz_sound.sv
// Purpose: Register file and sequencing of a buzzer and melody sound generator
// Assumes: Source clock ticks arrive as enables; waveform timing is simplified
// Notes: Tone period derives from the pitch field, duty from the length field in buzzer modes, in generator ticks
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`include "mbz_params.svh"
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Debug run bit set keeps the generator clock running in debug mode.
// - Oscillator sources divide by 4 to 128 for codes 0 to 5.
// - Source codes 0-3 pick the clock; crystal and external only undivided, code 7.
// - Tempo field sets melody tempo or one-shot length, 16 steps.
// - Drive select 1 gives normal drive, 0 direct drive of pins.
// - Mode field: 0 normal buzzer, 1 one-shot, 2 melody, 3 reserved.
// - Stop write of 1 ends output; bit reads 1 until output completes.
// - Stop also forcibly ends one-shot and melody output.
// - Stop with buffer full loads buffer after current waveform and continues.
// - Enable bit gates operation and the generator clock.
// - Data register is a one-word buffer; a write while idle starts output.
// - Tie bit joins melody note to previous; ignored otherwise and on first note.
// - Rest in melody holds buzzer low, inverted output high under normal drive, low under direct drive.
// - Length field is note duration in melody, duty in buzzer modes.
// - Pitch field: scale in melody, low six bits as frequency in buzzer modes.
// - Only full 16-bit writes reach the data register.
// - Buffer empty flag resets to 1, cleared by a data write.
// - Done flag resets 0, cleared by writing 1 or a data write.
// - Busy flag reads 1 while sound is output.
// - Loading the buffer sets empty and busy flags.
// - Interrupt request only when a flag and its enable are both set.
module mbz_sound (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [`MBZ_ADDR_W-1:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic wr_full_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    input wire logic debug_mode_i,
    input wire logic [3:0] src_tick_i,
    output logic buzzer_out_o,
    output logic buzzer_out_inverted_o,
    output logic buffer_empty_irq_o,
    output logic output_done_irq_o
);
    logic debug_run_reg;
    logic [2:0] clock_divider_select_reg;
    logic [1:0] clock_source_select_reg;
    logic [3:0] tempo_duration_field_reg;
    logic pin_drive_select_reg;
    logic [1:0] output_mode_field_reg;
    logic stop_request_reg;
    logic generator_enable_reg;
    logic [15:0] sound_data_buffer_reg;
    logic [15:0] sound_reg;
    logic buffer_empty_flag_reg;
    logic output_done_flag_reg;
    logic buffer_empty_irq_enable_reg;
    logic output_done_irq_enable_reg;
    logic [15:0] rdata_reg;
    logic buzz_reg;
    logic first_reg;
    logic [7:0] phase_reg;
    logic [17:0] dur_reg;
    mbz_pkg::mbz_state_t state_reg;
    mbz_pkg::mbz_state_t state_next;

    logic clk_run;
    logic tick;
    logic wr_clk;
    logic wr_sel;
    logic wr_ctl;
    logic wr_dat;
    logic wr_intf;
    logic wr_inte;
    logic load;
    logic finish;
    logic wave_end;
    logic [7:0] period;
    logic [7:0] high_len;
    logic [17:0] load_dur;
    logic note_done;
    logic melody;
    logic is_rest;
    logic tone;

    function automatic logic hit(input logic [`MBZ_ADDR_W-1:0] a,
                                 input logic [`MBZ_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    // Clock withheld in debug mode unless debug run is set
    assign clk_run = generator_enable_reg && (!debug_mode_i || debug_run_reg);

    mbz_clkgen u_clkgen (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .run_i(clk_run),
        .src_i(clock_source_select_reg),
        .div_i(clock_divider_select_reg),
        .src_tick_i(src_tick_i),
        .tick_o(tick)
    );

    assign wr_clk = wr_i && hit(addr_i, `MBZ_OFS_CLK);
    assign wr_sel = wr_i && hit(addr_i, `MBZ_OFS_SEL);
    assign wr_ctl = wr_i && hit(addr_i, `MBZ_OFS_CTL);
    assign wr_dat = wr_i && wr_full_i && hit(addr_i, `MBZ_OFS_DAT);
    assign wr_intf = wr_i && hit(addr_i, `MBZ_OFS_INTF);
    assign wr_inte = wr_i && hit(addr_i, `MBZ_OFS_INTE);

    assign melody = (output_mode_field_reg == mbz_pkg::MBZ_MODE_MELODY);
    // Buzzer modes use only the low six pitch bits
    assign period = melody ? sound_reg[7:0] : {2'b00, sound_reg[5:0]};
    // Duty in buzzer modes: length field in ticks, half the period when it exceeds the period
    assign high_len = melody ? {1'b0, period[7:1]}
                             : ((sound_reg[13:8] > period[5:0]) ? {1'b0, period[7:1]}
                                                                : {2'b00, sound_reg[13:8]});
    assign wave_end = tick && (phase_reg >= period);
    assign note_done = (dur_reg == 18'h00000) && wave_end;
    // Waveform ends on period boundary; a pending buffer word loads there in stop, or at note end in melody
    assign load = (state_reg != mbz_pkg::MBZ_ST_STOP || !buffer_empty_flag_reg)
                  && !buffer_empty_flag_reg
                  && ((state_reg == mbz_pkg::MBZ_ST_IDLE && tick)
                      || (state_reg == mbz_pkg::MBZ_ST_PLAY && melody && note_done)
                      || (state_reg == mbz_pkg::MBZ_ST_STOP && wave_end));
    assign finish = !load && ((state_reg == mbz_pkg::MBZ_ST_STOP && wave_end)
                    || (state_reg == mbz_pkg::MBZ_ST_PLAY
                        && output_mode_field_reg != mbz_pkg::MBZ_MODE_NORMAL && note_done));
    // Length in ticks: melody uses tempo times (length+1), one-shot tempo steps
    assign load_dur = melody
        ? 18'((`MBZ_TEMPO_BASE * (tempo_duration_field_reg + 1)) * (sound_data_buffer_reg[13:8] + 1) / 4)
        : 18'(`MBZ_SHOT_BASE + `MBZ_SHOT_STEP * tempo_duration_field_reg);
    assign is_rest = melody && sound_reg[`MBZ_DAT_REST];
    assign tone = (state_reg != mbz_pkg::MBZ_ST_IDLE) && !is_rest && buzz_reg;

    always_comb begin
        case (state_reg)
            mbz_pkg::MBZ_ST_IDLE: state_next = load ? mbz_pkg::MBZ_ST_PLAY : mbz_pkg::MBZ_ST_IDLE;
            mbz_pkg::MBZ_ST_PLAY: state_next = (wr_ctl && wdata_i[`MBZ_CTL_STOP])
                                               ? mbz_pkg::MBZ_ST_STOP
                                               : (finish ? mbz_pkg::MBZ_ST_IDLE
                                                         : mbz_pkg::MBZ_ST_PLAY);
            mbz_pkg::MBZ_ST_STOP: state_next = load ? mbz_pkg::MBZ_ST_PLAY
                                               : (finish ? mbz_pkg::MBZ_ST_IDLE
                                                         : mbz_pkg::MBZ_ST_STOP);
            default: state_next = mbz_pkg::MBZ_ST_IDLE;
        endcase
        if (!generator_enable_reg) begin
            state_next = mbz_pkg::MBZ_ST_IDLE;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= mbz_pkg::MBZ_ST_IDLE;
            sound_reg <= `MBZ_DAT_RESET;
            phase_reg <= 8'h00;
            dur_reg <= 18'h00000;
            buzz_reg <= 1'b0;
            first_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            if (load) begin
                sound_reg <= sound_data_buffer_reg;
                // Tie keeps phase running so tied notes play as one
                if (!(melody && sound_data_buffer_reg[`MBZ_DAT_TIE] && !first_reg)) begin
                    phase_reg <= 8'h00;
                end
                dur_reg <= load_dur;
                first_reg <= 1'b0;
            end else if (tick && state_reg != mbz_pkg::MBZ_ST_IDLE) begin
                phase_reg <= wave_end ? 8'h00 : phase_reg + 8'h01;
                buzz_reg <= (phase_reg < high_len);
                if (dur_reg != 18'h00000) begin
                    dur_reg <= dur_reg - 18'h00001;
                end
            end
            if (state_next == mbz_pkg::MBZ_ST_IDLE) begin
                first_reg <= 1'b1;
                buzz_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            debug_run_reg <= 1'b0;
            clock_divider_select_reg <= 3'h0;
            clock_source_select_reg <= 2'h0;
            tempo_duration_field_reg <= 4'h0;
            pin_drive_select_reg <= 1'b0;
            output_mode_field_reg <= 2'h0;
            generator_enable_reg <= 1'b0;
            buffer_empty_irq_enable_reg <= 1'b0;
            output_done_irq_enable_reg <= 1'b0;
            sound_data_buffer_reg <= `MBZ_DAT_RESET;
        end else begin
            // Clock settings frozen while enabled, protects the divider
            if (wr_clk && !generator_enable_reg) begin
                debug_run_reg <= wdata_i[`MBZ_CLK_DEBUG_RUN];
                clock_divider_select_reg <= wdata_i[`MBZ_CLK_DIV_LSB +: 3];
                clock_source_select_reg <= wdata_i[`MBZ_CLK_SRC_LSB +: 2];
            end
            if (wr_sel) begin
                tempo_duration_field_reg <= wdata_i[`MBZ_SEL_TEMPO_LSB +: 4];
                pin_drive_select_reg <= wdata_i[`MBZ_SEL_DRIVE];
                output_mode_field_reg <= wdata_i[`MBZ_SEL_MODE_LSB +: 2];
            end
            if (wr_ctl) begin
                generator_enable_reg <= wdata_i[`MBZ_CTL_EN];
            end
            if (wr_inte) begin
                buffer_empty_irq_enable_reg <= wdata_i[`MBZ_INTE_EMPTY];
                output_done_irq_enable_reg <= wdata_i[`MBZ_INTE_DONE];
            end
            if (wr_dat) begin
                sound_data_buffer_reg <= wdata_i;
            end
        end
    end

    // Flags: hardware set wins over software clear in the same cycle
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            buffer_empty_flag_reg <= 1'b1;
            output_done_flag_reg <= 1'b0;
            stop_request_reg <= 1'b0;
        end else begin
            if (load) begin
                buffer_empty_flag_reg <= 1'b1;
            end else if (wr_dat) begin
                buffer_empty_flag_reg <= 1'b0;
            end
            if (finish) begin
                output_done_flag_reg <= 1'b1;
            end else if (wr_dat || (wr_intf && wdata_i[`MBZ_INTF_DONE])) begin
                output_done_flag_reg <= 1'b0;
            end
            if (state_next == mbz_pkg::MBZ_ST_IDLE) begin
                stop_request_reg <= 1'b0;
            end else if (wr_ctl && wdata_i[`MBZ_CTL_STOP]) begin
                stop_request_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_reg <= 16'h0000;
        end else if (rd_i) begin
            case (addr_i)
                `MBZ_OFS_CLK: rdata_reg <= {7'h00, debug_run_reg, 1'b0, clock_divider_select_reg,
                                            2'h0, clock_source_select_reg};
                `MBZ_OFS_SEL: rdata_reg <= {4'h0, tempo_duration_field_reg, 5'h00,
                                            pin_drive_select_reg, output_mode_field_reg};
                `MBZ_OFS_CTL: rdata_reg <= {7'h00, stop_request_reg, 7'h00, generator_enable_reg};
                `MBZ_OFS_DAT: rdata_reg <= sound_data_buffer_reg;
                `MBZ_OFS_INTF: rdata_reg <= {7'h00, (state_reg != mbz_pkg::MBZ_ST_IDLE), 6'h00,
                                             buffer_empty_flag_reg, output_done_flag_reg};
                `MBZ_OFS_INTE: rdata_reg <= {14'h0000, buffer_empty_irq_enable_reg,
                                             output_done_irq_enable_reg};
                default: rdata_reg <= 16'h0000;
            endcase
        end else begin
            rdata_reg <= 16'h0000;
        end
    end

    assign rdata_o = rdata_reg;
    assign buffer_empty_irq_o = buffer_empty_flag_reg && buffer_empty_irq_enable_reg;
    assign output_done_irq_o = output_done_flag_reg && output_done_irq_enable_reg;
    // Normal drive gives complementary pins; direct drive holds the inverted pin low
    assign buzzer_out_o = tone;
    assign buzzer_out_inverted_o = pin_drive_select_reg ? !tone : 1'b0;
endmodule
`default_nettype wire

// >>> tb/mbz_sound_checker.sv
// Purpose: Port checks of the sound generator
// Assumes: Register shadows follow the strobe port
// Notes: Flags are not shadowed; the bench checks them
`include "mbz_params.svh"
`timescale 1ns/1ps
`default_nettype none
module mbz_sound_checker (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [`MBZ_ADDR_W-1:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic wr_full_i,
    input wire logic rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic buzzer_out_inverted_o,
    input wire logic buffer_empty_irq_o,
    input wire logic output_done_irq_o
);
    logic [15:0] clk_reg, sel_reg, dat_reg, rmask_reg;
    logic en_reg;
    logic [1:0] inte_reg;
    wire logic [15:0] rmask_next = !rd_i ? 16'h0000 :
        (addr_i == `MBZ_OFS_CLK) ? 16'h0173 : (addr_i == `MBZ_OFS_SEL) ? 16'h0F07 :
        (addr_i == `MBZ_OFS_CTL) ? 16'h0101 : (addr_i == `MBZ_OFS_DAT) ? 16'hFFFF :
        (addr_i == `MBZ_OFS_INTF) ? 16'h0103 : (addr_i == `MBZ_OFS_INTE) ? 16'h0003 : 16'h0000;
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            clk_reg <= 16'h0000;
            sel_reg <= 16'h0000;
            dat_reg <= `MBZ_DAT_RESET;
            rmask_reg <= 16'h0000;
            en_reg <= 1'b0;
            inte_reg <= 2'h0;
        end else begin
            rmask_reg <= rmask_next;
            // Clock settings are frozen while enabled
            if (wr_i && addr_i == `MBZ_OFS_CLK && !en_reg) clk_reg <= wdata_i & 16'h0173;
            if (wr_i && addr_i == `MBZ_OFS_SEL) sel_reg <= wdata_i & 16'h0F07;
            if (wr_i && addr_i == `MBZ_OFS_DAT && wr_full_i) dat_reg <= wdata_i;
            if (wr_i && addr_i == `MBZ_OFS_CTL) en_reg <= wdata_i[0];
            if (wr_i && addr_i == `MBZ_OFS_INTE) inte_reg <= wdata_i[1:0];
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    AST_RD_RESERVED_ZERO: assert property ((rdata_o & ~rmask_reg) == 16'h0000)
        else $error("read data outside mapped bits");
    AST_CLK_READBACK: assert property (rd_i && addr_i == `MBZ_OFS_CLK |=> rdata_o == clk_reg)
        else $error("clock select readback wrong");
    AST_SEL_READBACK: assert property (rd_i && addr_i == `MBZ_OFS_SEL |=> rdata_o == sel_reg)
        else $error("mode select readback wrong");
    AST_DAT_READBACK: assert property (rd_i && addr_i == `MBZ_OFS_DAT |=> rdata_o == dat_reg)
        else $error("data buffer readback wrong");
    AST_EN_READBACK: assert property (rd_i && addr_i == `MBZ_OFS_CTL |=> rdata_o[0] == $past(en_reg))
        else $error("enable readback wrong");
    AST_INTE_READBACK: assert property (rd_i && addr_i == `MBZ_OFS_INTE |=> rdata_o[1:0] == inte_reg)
        else $error("irq enable readback wrong");
    AST_EMPTY_IRQ_GATED: assert property (buffer_empty_irq_o |-> inte_reg[1])
        else $error("empty irq without enable");
    AST_DONE_IRQ_GATED: assert property (output_done_irq_o |-> inte_reg[0])
        else $error("done irq without enable");
    AST_DIRECT_DRIVE: assert property (!sel_reg[2] |-> !buzzer_out_inverted_o)
        else $error("inverted pin driven in direct mode");
endmodule
bind mbz_sound mbz_sound_checker u_chk (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .wr_full_i(wr_full_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .buzzer_out_inverted_o(buzzer_out_inverted_o), .buffer_empty_irq_o(buffer_empty_irq_o),
    .output_done_irq_o(output_done_irq_o));
`default_nettype wire

// >>> tb/test_mbz_sound.sv
// Purpose: Self-checking bench of the sound generator
// Assumes: Reads are compared from a queue of notes
// Notes: Waveform timing is not checked, only registers, flags and pins
`include "mbz_params.svh"
`timescale 1ns/1ps
`default_nettype none
module test_mbz_sound;
    typedef struct packed {logic [15:0] exp; logic [15:0] msk;} mbz_note_t;
    localparam logic [3:0] A_CLK = `MBZ_OFS_CLK, A_SEL = `MBZ_OFS_SEL, A_CTL = `MBZ_OFS_CTL;
    localparam logic [3:0] A_DAT = `MBZ_OFS_DAT, A_INTF = `MBZ_OFS_INTF, A_INTE = `MBZ_OFS_INTE;
    logic mclk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, wr_full_i = 1'b0, rd_i = 1'b0;
    logic debug_mode_i = 1'b0, rd_q = 1'b0;
    logic [3:0] addr_i = 4'h0, src_tick_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000, last_rd, r, d;
    wire logic [15:0] rdata_o;
    wire logic bz, bzn, irq_e, irq_d;
    int err_count = 0, n_tests = 0, i;
    mbz_note_t notes[$], cur;
    mbz_sound DUT (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .wr_full_i(wr_full_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .debug_mode_i(debug_mode_i), .src_tick_i(src_tick_i), .buzzer_out_o(bz),
        .buzzer_out_inverted_o(bzn), .buffer_empty_irq_o(irq_e), .output_done_irq_o(irq_d));
    always #5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        src_tick_i <= 4'($urandom);
        rd_q <= rd_i;
    end
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    always @(negedge mclk_i) begin
        if (rd_q === 1'b1) begin
            last_rd = rdata_o;
            cur = notes.pop_front();
            if (cur.msk !== 16'h0000) chk16(rdata_o & cur.msk, cur.exp);
        end
    end
    task automatic wr(input logic [3:0] a, input logic [15:0] v, input logic full = 1'b1);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_full_i <= full;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
        notes.push_back('{e, m});
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        @(negedge mclk_i);
        #1;
    endtask
    // Polls one status bit; the bound keeps a stuck flag from hanging the run
    task automatic poll(input logic [3:0] a, input int b, input logic v);
        int k;
        k = 0;
        rd(a, 16'h0000, 16'h0000);
        while (last_rd[b] !== v && k < 5000) begin
            rd(a, 16'h0000, 16'h0000);
            k++;
        end
        chk16({15'h0000, last_rd[b]}, {15'h0000, v});
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #500_000;
        err_count++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, 16'h0000, 16'hFFFF);
        give_verdict();
    end
    initial begin
        void'($urandom(39235));
        repeat (4) @(posedge mclk_i);
        nrst_i <= 1'b1;
        rd(A_CLK, 16'h0000);
        rd(A_SEL, 16'h0000);
        rd(A_CTL, 16'h0000);
        rd(A_DAT, `MBZ_DAT_RESET);
        rd(A_INTF, 16'h0002);
        rd(A_INTE, 16'h0000);
        for (i = 6; i < 16; i++) rd(4'(i), 16'h0000);
        $display("test reset values done");
        r = 16'($urandom);
        wr(A_CLK, r);
        rd(A_CLK, r & 16'h0173);
        for (i = 0; i < 4; i++) begin
            wr(A_SEL, {4'h0, 4'(i * 5), 6'h00, 2'(i)});
            rd(A_SEL, {4'h0, 4'(i * 5), 6'h00, 2'(i)});
            chk16({15'h0000, bzn}, 16'h0000);
        end
        wr(A_INTE, 16'hFFFF);
        rd(A_INTE, 16'h0003);
        wr(A_CTL, 16'h0001);
        wr(A_CLK, ~r);
        rd(A_CLK, r & 16'h0173);
        rd(A_CTL, 16'h0001);
        wr(A_CTL, 16'h0000);
        $display("test register access done");
        d = {2'b00, 6'($urandom), 2'b00, 6'($urandom)};
        wr(A_DAT, ~d, 1'b0);
        rd(A_DAT, `MBZ_DAT_RESET);
        rd(A_INTF, 16'h0002);
        wr(A_DAT, d);
        rd(A_DAT, d);
        rd(A_INTF, 16'h0000);
        $display("test buffer write done");
        wr(A_CLK, 16'h0000);
        wr(A_SEL, 16'h0005);
        debug_mode_i <= 1'b1;
        wr(A_CTL, 16'h0001);
        repeat (3000) @(posedge mclk_i);
        rd(A_INTF, 16'h0000);
        @(posedge mclk_i);
        debug_mode_i <= 1'b0;
        poll(A_INTF, 8, 1'b1);
        rd(A_INTF, 16'h0102, 16'h0102);
        chk16({15'h0000, irq_e}, 16'h0001);
        poll(A_INTF, 0, 1'b1);
        rd(A_INTF, 16'h0003);
        chk16({15'h0000, irq_d}, 16'h0001);
        $display("test one-shot done");
        wr(A_SEL, 16'h0004);
        wr(A_DAT, d);
        rd(A_INTF, 16'h0000, 16'h0001);
        poll(A_INTF, 8, 1'b1);
        repeat (2000) @(posedge mclk_i);
        rd(A_INTF, 16'h0100, 16'h0100);
        // Freeze the generator clock so a short period cannot end the stop before the read
        @(posedge mclk_i);
        debug_mode_i <= 1'b1;
        wr(A_CTL, 16'h0101);
        rd(A_CTL, 16'h0101);
        @(posedge mclk_i);
        debug_mode_i <= 1'b0;
        poll(A_CTL, 8, 1'b0);
        rd(A_INTF, 16'h0000, 16'h0100);
        wr(A_INTF, 16'h0001);
        rd(A_INTF, 16'h0000, 16'h0001);
        $display("test normal buzzer stop done");
        wr(A_SEL, 16'h0006);
        wr(A_DAT, 16'h407C);
        poll(A_INTF, 8, 1'b1);
        chk16({15'h0000, bz}, 16'h0000);
        chk16({15'h0000, bzn}, 16'h0001);
        wr(A_DAT, 16'hC07C);
        rd(A_INTF, 16'h0000, 16'h0002);
        wr(A_CTL, 16'h0101);
        poll(A_INTF, 1, 1'b1);
        poll(A_CTL, 8, 1'b0);
        rd(A_INTF, 16'h0002, 16'h0102);
        $display("test melody rest and stop done");
        give_verdict();
    end
endmodule
`default_nettype wire
